// ---- t16b_pkg.sv ----
// package: register map, field layout, reset values and types of the timer
package t16b_pkg;
	// byte register indices (word address = index, byte address = 4*index)
	localparam logic [3:0] ADDR_CTRL_A   = 4'h0; // timer_control_a
	localparam logic [3:0] ADDR_CTRL_B   = 4'h1; // timer_control_b
	localparam logic [3:0] ADDR_FLAGS    = 4'h2; // timer_flag_register
	localparam logic [3:0] ADDR_MASK     = 4'h3; // timer_mask_register
	localparam logic [3:0] ADDR_CNT_LO   = 4'h4; // count_low_byte
	localparam logic [3:0] ADDR_CNT_HI   = 4'h5; // count_high_byte
	localparam logic [3:0] ADDR_CMPA_LO  = 4'h6;
	localparam logic [3:0] ADDR_CMPA_HI  = 4'h7;
	localparam logic [3:0] ADDR_CMPB_LO  = 4'h8;
	localparam logic [3:0] ADDR_CMPB_HI  = 4'h9;
	localparam logic [3:0] ADDR_CAP_LO   = 4'ha;
	localparam logic [3:0] ADDR_CAP_HI   = 4'hb;
	// control b fields
	localparam int CS_LSB    = 0;  // clock select, 3 bits
	localparam int TOPSEL_LSB = 3; // top select, 3 bits
	localparam int CAPEDGE_BIT = 6; // capture on rising edge when 1
	localparam int CAPSRC_BIT  = 7; // capture from comparator when 1
	// control a fields
	localparam int NCAN_BIT  = 0;  // noise filter enable
	localparam int PWMA_BIT  = 1;  // channel a pwm output enable
	localparam int PWMB_BIT  = 2;  // channel b pwm output enable
	// flag / mask bit positions
	localparam int FLG_OVF  = 0;
	localparam int FLG_CMPA = 1;
	localparam int FLG_CMPB = 2;
	localparam int FLG_CAP  = 3;
	// reset values
	localparam logic [7:0]  RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;
	// end points
	localparam logic [15:0] BOTTOM_VAL = 16'h0000;
	localparam logic [15:0] MAX_VAL    = 16'hffff;
	localparam logic [15:0] TOP_8BIT   = 16'h00ff;
	localparam logic [15:0] TOP_9BIT   = 16'h01ff;
	localparam logic [15:0] TOP_10BIT  = 16'h03ff;
	// noise filter sample count
	localparam logic [1:0]  NCAN_LAST  = 2'h3;
	// prescaler terminal counts (divide by n means count n-1)
	localparam logic [9:0]  DIV8_TC    = 10'h007;
	localparam logic [9:0]  DIV64_TC   = 10'h03f;
	localparam logic [9:0]  DIV256_TC  = 10'h0ff;
	localparam logic [9:0]  DIV1024_TC = 10'h3ff;

	typedef enum logic [2:0] {
		T16B_CS_OFF, T16B_CS_DIV1, T16B_CS_DIV8, T16B_CS_DIV64,
		T16B_CS_DIV256, T16B_CS_DIV1024, T16B_CS_EXT_FALL, T16B_CS_EXT_RISE
	} t16b_cs_t;

	typedef enum logic [2:0] {
		T16B_TOP_MAX, T16B_TOP_8BIT, T16B_TOP_9BIT, T16B_TOP_10BIT,
		T16B_TOP_CMPA, T16B_TOP_CAP, T16B_TOP_R6, T16B_TOP_R7
	} t16b_top_t;

	// pin-side signals carried together
	typedef struct packed {
		logic count_pin;
		logic capture_pin;
		logic comparator;
	} t16b_pins_t;

	typedef struct packed {
		logic at_bottom;
		logic at_max;
		logic at_top;
	} t16b_ends_t;
endpackage

// ---- t16b_core.sv ----
// top module: 16-bit timer with byte access through a shared high byte
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/100ps
// How it works
// - sixteen-bit values reached as two bytes
// - control registers are plain eight-bit registers
// - one shared high-byte holding register
// - low byte write loads holding plus data
// - count or capture low byte read copies high into holding
// - compare high bytes read directly, holding untouched
// - counter steps only on selected tick
// - equality with compare on a counting tick sets match flag
// - compare values double buffered
// - every request shows in flag register
// - each request masked by own bit
// - capture edge latches counter, optional filter
// - signal bottom at zero, max at ffff
// - top selectable fixed, compare a, capture
// - compare a as top disables its pwm
// - capture as top frees compare a
// - processor counter write beats count step
// - capture flag set with capture copy
module t16b_core (
	input  wire logic               clk_in,
	input  wire logic               srst_in,
	input  wire logic               ce_in,
	input  wire logic [3:0]         avs_address_in,
	input  wire logic               avs_read_in,
	input  wire logic               avs_write_in,
	input  wire logic [31:0]        avs_writedata_in,
	input  wire logic [3:0]         avs_byteenable_in,
	output logic      [31:0]        avs_readdata_out,
	output logic                    avs_waitrequest_out,
	input  wire t16b_pkg::t16b_pins_t pins_in,
	output logic      [1:0]         compare_output_pins_out,
	output logic                    irq_out,
	output t16b_pkg::t16b_ends_t    ends_out
);
	////////////////////////////////////////////////////////////////////////
	// registers
	logic [7:0]  timer_control_a_ff, timer_control_b_ff;
	logic [3:0]  timer_flag_register_ff, timer_mask_register_ff;
	logic [7:0]  hold_ff;
	logic [15:0] timer_count_value_ff;
	logic [15:0] cmpa_buf_ff, cmpb_buf_ff, cmpa_act_ff, cmpb_act_ff;
	logic [15:0] capture_value_ff;
	logic        ack_ff;
	logic        wait_ff;
	logic [31:0] rdata_ff;
	logic [1:0]  pwm_ff;
	logic        irq_ff;
	t16b_pkg::t16b_ends_t ends_ff;
	logic [2:0]  pin_s1_ff, pin_s2_ff;
	logic        cnt_prev_ff, cap_prev_ff;
	logic [1:0]  ncan_cnt_ff;
	logic        ncan_out_ff;
	logic [9:0]  pre_ff;

	////////////////////////////////////////////////////////////////////////
	// bus decode: one wait state, answer when ack_ff is high
	wire        req     = (avs_read_in | avs_write_in) & ~ack_ff & ce_in;
	wire        wr_lane = avs_write_in & avs_byteenable_in[0];
	wire        wr      = req & wr_lane;
	wire        rd      = req & avs_read_in;
	wire [7:0]  wdata   = avs_writedata_in[7:0];
	wire        wr_cnt_lo  = wr & (avs_address_in == t16b_pkg::ADDR_CNT_LO);
	wire        wr_cmpa_lo = wr & (avs_address_in == t16b_pkg::ADDR_CMPA_LO);
	wire        wr_cmpb_lo = wr & (avs_address_in == t16b_pkg::ADDR_CMPB_LO);
	wire        wr_cap_lo  = wr & (avs_address_in == t16b_pkg::ADDR_CAP_LO);
	// any high byte address writes the holding register
	wire        wr_hi = wr & avs_address_in[0] & (avs_address_in >= 4'h5) &
	                    (avs_address_in <= t16b_pkg::ADDR_CAP_HI);
	wire        rd_cnt_lo = rd & (avs_address_in == t16b_pkg::ADDR_CNT_LO);
	wire        rd_cap_lo = rd & (avs_address_in == t16b_pkg::ADDR_CAP_LO);
	wire        wr_flags  = wr & (avs_address_in == t16b_pkg::ADDR_FLAGS);

	////////////////////////////////////////////////////////////////////////
	// mode decode
	wire [2:0]  cs_sel  = timer_control_b_ff[t16b_pkg::CS_LSB +: 3];
	wire [2:0]  top_sel = timer_control_b_ff[t16b_pkg::TOPSEL_LSB +: 3];
	wire        top_cmpa = (top_sel == 3'(t16b_pkg::T16B_TOP_CMPA));
	wire        top_cap  = (top_sel == 3'(t16b_pkg::T16B_TOP_CAP));
	logic [15:0] top_val;
	// top choice per mode
	always_comb begin
		case (t16b_pkg::t16b_top_t'(top_sel))
		t16b_pkg::T16B_TOP_8BIT:  top_val = t16b_pkg::TOP_8BIT;
		t16b_pkg::T16B_TOP_9BIT:  top_val = t16b_pkg::TOP_9BIT;
		t16b_pkg::T16B_TOP_10BIT: top_val = t16b_pkg::TOP_10BIT;
		t16b_pkg::T16B_TOP_CMPA:  top_val = cmpa_act_ff;
		t16b_pkg::T16B_TOP_CAP:   top_val = capture_value_ff;
		default:                  top_val = t16b_pkg::MAX_VAL;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// prescaler and tick select
	wire cnt_pin  = pin_s2_ff[2];
	wire cnt_rise = cnt_pin & ~cnt_prev_ff;
	wire cnt_fall = ~cnt_pin & cnt_prev_ff;
	logic tick;
	always_comb begin
		case (t16b_pkg::t16b_cs_t'(cs_sel))
		t16b_pkg::T16B_CS_OFF:      tick = 1'b0;
		t16b_pkg::T16B_CS_DIV1:     tick = 1'b1;
		t16b_pkg::T16B_CS_DIV8:     tick = (pre_ff[2:0] == t16b_pkg::DIV8_TC[2:0]);
		t16b_pkg::T16B_CS_DIV64:    tick = (pre_ff[5:0] == t16b_pkg::DIV64_TC[5:0]);
		t16b_pkg::T16B_CS_DIV256:   tick = (pre_ff[7:0] == t16b_pkg::DIV256_TC[7:0]);
		t16b_pkg::T16B_CS_DIV1024:  tick = (pre_ff == t16b_pkg::DIV1024_TC);
		t16b_pkg::T16B_CS_EXT_FALL: tick = cnt_fall;
		t16b_pkg::T16B_CS_EXT_RISE: tick = cnt_rise;
		default:                    tick = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// counter: wraps at top; cpu write overrides the step
	wire        at_top   = (timer_count_value_ff == top_val);
	wire [15:0] cnt_step = at_top ? t16b_pkg::BOTTOM_VAL
	                              : timer_count_value_ff + 16'h0001;
	wire [15:0] nxt_count = wr_cnt_lo ? {hold_ff, wdata} :
	                        tick ? cnt_step : timer_count_value_ff;
	wire        ovf_evt  = tick & at_top & ~wr_cnt_lo;

	// compare: active value reloads from buffer at top
	wire match_a = (timer_count_value_ff == cmpa_act_ff);
	wire match_b = (timer_count_value_ff == cmpb_act_ff);
	wire load_act = ovf_evt | (cs_sel == 3'h0); // stopped timer loads at once
	wire cmpa_evt = tick & match_a;
	wire cmpb_evt = tick & match_b;

	////////////////////////////////////////////////////////////////////////
	// capture: filter over four equal samples, then edge detect
	wire cap_raw = timer_control_b_ff[t16b_pkg::CAPSRC_BIT] ? pin_s2_ff[0]
	                                                        : pin_s2_ff[1];
	wire ncan_on = timer_control_a_ff[t16b_pkg::NCAN_BIT];
	wire cap_lvl = ncan_on ? ncan_out_ff : cap_raw;
	wire cap_rise_sel = timer_control_b_ff[t16b_pkg::CAPEDGE_BIT];
	wire cap_edge = cap_rise_sel ? (cap_lvl & ~cap_prev_ff)
	                             : (~cap_lvl & cap_prev_ff);
	// capture is off when capture register supplies top
	wire cap_evt = cap_edge & ~top_cap;
	wire [15:0] nxt_cap = wr_cap_lo & top_cap ? {hold_ff, wdata} :
	                      cap_evt ? timer_count_value_ff : capture_value_ff;

	////////////////////////////////////////////////////////////////////////
	// flags: hardware set wins over write-one-to-clear
	wire [3:0] set_flags = {cap_evt, cmpb_evt, cmpa_evt, ovf_evt};
	wire [3:0] clr_flags = wr_flags ? wdata[3:0] : 4'h0;
	wire [3:0] nxt_flags = set_flags |
	                       (timer_flag_register_ff & ~clr_flags);

	// holding register next value
	wire [7:0] nxt_hold = wr_hi ? wdata :
	                      rd_cnt_lo ? timer_count_value_ff[15:8] :
	                      rd_cap_lo ? capture_value_ff[15:8] : hold_ff;

	////////////////////////////////////////////////////////////////////////
	// read mux: high of count/capture from holding, compare high direct
	logic [7:0] rd_byte;
	always_comb begin
		case (avs_address_in)
		t16b_pkg::ADDR_CTRL_A:  rd_byte = timer_control_a_ff;
		t16b_pkg::ADDR_CTRL_B:  rd_byte = timer_control_b_ff;
		t16b_pkg::ADDR_FLAGS:   rd_byte = {4'h0, timer_flag_register_ff};
		t16b_pkg::ADDR_MASK:    rd_byte = {4'h0, timer_mask_register_ff};
		t16b_pkg::ADDR_CNT_LO:  rd_byte = timer_count_value_ff[7:0];
		t16b_pkg::ADDR_CNT_HI:  rd_byte = hold_ff;
		t16b_pkg::ADDR_CMPA_LO: rd_byte = cmpa_buf_ff[7:0];
		t16b_pkg::ADDR_CMPA_HI: rd_byte = cmpa_buf_ff[15:8];
		t16b_pkg::ADDR_CMPB_LO: rd_byte = cmpb_buf_ff[7:0];
		t16b_pkg::ADDR_CMPB_HI: rd_byte = cmpb_buf_ff[15:8];
		t16b_pkg::ADDR_CAP_LO:  rd_byte = capture_value_ff[7:0];
		t16b_pkg::ADDR_CAP_HI:  rd_byte = hold_ff;
		default:                rd_byte = t16b_pkg::RST_BYTE;
		endcase
	end

	// pwm: set at top, clear on match; a off when it is the top
	wire pwm_a_en = timer_control_a_ff[t16b_pkg::PWMA_BIT] & ~top_cmpa;
	wire pwm_b_en = timer_control_a_ff[t16b_pkg::PWMB_BIT];
	wire [1:0] nxt_pwm = {pwm_b_en & (match_b ? 1'b0 : at_top ? 1'b1 : pwm_ff[1]),
	                      pwm_a_en & (match_a ? 1'b0 : at_top ? 1'b1 : pwm_ff[0])};

	////////////////////////////////////////////////////////////////////////
	// synchronisers; first stage only feeds the second
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			pin_s1_ff <= 3'h0;
			pin_s2_ff <= 3'h0;
		end else if (ce_in) begin
			pin_s1_ff <= pins_in;
			pin_s2_ff <= pin_s1_ff;
		end
	end

	// edge history, prescaler and noise filter
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			cnt_prev_ff <= 1'b0;
			cap_prev_ff <= 1'b0;
			pre_ff      <= 10'h000;
			ncan_cnt_ff <= 2'h0;
			ncan_out_ff <= 1'b0;
		end else if (ce_in) begin
			cnt_prev_ff <= cnt_pin;
			cap_prev_ff <= cap_lvl;
			pre_ff      <= pre_ff + 10'h001;
			ncan_cnt_ff <= (cap_raw == ncan_out_ff) ? 2'h0 : ncan_cnt_ff + 2'h1;
			if (cap_raw != ncan_out_ff && ncan_cnt_ff == t16b_pkg::NCAN_LAST)
				ncan_out_ff <= cap_raw;
		end
	end

	// control and holding registers
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			timer_control_a_ff     <= t16b_pkg::RST_BYTE;
			timer_control_b_ff     <= t16b_pkg::RST_BYTE;
			timer_mask_register_ff <= 4'h0;
			timer_flag_register_ff <= 4'h0;
			hold_ff                <= t16b_pkg::RST_BYTE;
		end else if (ce_in) begin
			if (wr & (avs_address_in == t16b_pkg::ADDR_CTRL_A))
				timer_control_a_ff <= wdata;
			if (wr & (avs_address_in == t16b_pkg::ADDR_CTRL_B))
				timer_control_b_ff <= wdata;
			if (wr & (avs_address_in == t16b_pkg::ADDR_MASK))
				timer_mask_register_ff <= wdata[3:0];
			timer_flag_register_ff <= nxt_flags;
			hold_ff <= nxt_hold;
		end
	end

	// 16-bit values
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			timer_count_value_ff <= t16b_pkg::RST_WORD;
			cmpa_buf_ff          <= t16b_pkg::RST_WORD;
			cmpb_buf_ff          <= t16b_pkg::RST_WORD;
			cmpa_act_ff          <= t16b_pkg::RST_WORD;
			cmpb_act_ff          <= t16b_pkg::RST_WORD;
			capture_value_ff     <= t16b_pkg::RST_WORD;
		end else if (ce_in) begin
			timer_count_value_ff <= nxt_count;
			if (wr_cmpa_lo)
				cmpa_buf_ff <= {hold_ff, wdata};
			if (wr_cmpb_lo)
				cmpb_buf_ff <= {hold_ff, wdata};
			if (load_act) begin
				cmpa_act_ff <= cmpa_buf_ff;
				cmpb_act_ff <= cmpb_buf_ff;
			end
			capture_value_ff <= nxt_cap;
		end
	end

	// bus answer and outputs
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			ack_ff   <= 1'b0;
			wait_ff  <= 1'b1;
			rdata_ff <= 32'h0000_0000;
			pwm_ff   <= 2'h0;
			irq_ff   <= 1'b0;
			ends_ff  <= '0;
		end else if (ce_in) begin
			ack_ff <= req;
			wait_ff <= ~req; // own flop so the pin has no gate behind it
			if (rd)
				rdata_ff <= {24'h00_0000, rd_byte};
			pwm_ff <= nxt_pwm;
			irq_ff <= |(nxt_flags & timer_mask_register_ff);
			ends_ff.at_bottom <= (nxt_count == t16b_pkg::BOTTOM_VAL);
			ends_ff.at_max    <= (nxt_count == t16b_pkg::MAX_VAL);
			ends_ff.at_top    <= (nxt_count == top_val);
		end
	end

	assign avs_readdata_out        = rdata_ff;
	assign avs_waitrequest_out     = wait_ff;
	assign compare_output_pins_out = pwm_ff;
	assign irq_out                 = irq_ff;
	assign ends_out                = ends_ff;

	////////////////////////////////////////////////////////////////////////
	// checks
	property p_lo_write;
		@(posedge clk_in) disable iff (srst_in)
		wr_cnt_lo |=> timer_count_value_ff == $past({hold_ff, wdata});
	endproperty
	a_lo_write: assert property (p_lo_write) else $error("count load bad");
	property p_lo_read;
		@(posedge clk_in) disable iff (srst_in)
		rd_cnt_lo |=> hold_ff == $past(timer_count_value_ff[15:8]);
	endproperty
	a_lo_read: assert property (p_lo_read) else $error("hold not loaded");
	property p_cmp_read;
		@(posedge clk_in) disable iff (srst_in)
		(rd && avs_address_in == t16b_pkg::ADDR_CMPA_HI) |=> $stable(hold_ff);
	endproperty
	a_cmp_read: assert property (p_cmp_read) else $error("hold disturbed");
	property p_stop;
		@(posedge clk_in) disable iff (srst_in)
		(ce_in && cs_sel == 3'h0 && !wr_cnt_lo) |=> $stable(timer_count_value_ff);
	endproperty
	a_stop: assert property (p_stop) else $error("count moved");
	property p_cap_flag;
		@(posedge clk_in) disable iff (srst_in)
		(ce_in && cap_evt) |=> timer_flag_register_ff[t16b_pkg::FLG_CAP] &&
		capture_value_ff == $past(timer_count_value_ff);
	endproperty
	a_cap_flag: assert property (p_cap_flag) else $error("capture flag");
	property p_cmpa_flag;
		@(posedge clk_in) disable iff (srst_in)
		(ce_in && cmpa_evt) |=> timer_flag_register_ff[t16b_pkg::FLG_CMPA];
	endproperty
	a_cmpa_flag: assert property (p_cmpa_flag) else $error("match flag");
	property p_pwm_off;
		@(posedge clk_in) disable iff (srst_in)
		(ce_in && top_cmpa) |=> !compare_output_pins_out[0];
	endproperty
	a_pwm_off: assert property (p_pwm_off) else $error("pwm a on");
	sequence s_write_lo;
		ce_in && wr_cmpa_lo && !load_act;
	endsequence
	property p_buffered;
		@(posedge clk_in) disable iff (srst_in)
		s_write_lo |=> $stable(cmpa_act_ff);
	endproperty
	a_buffered: assert property (p_buffered) else $error("unbuffered");
	// every taken request is answered on the very next edge
	sequence s_taken;
		req && !srst_in;
	endsequence
	property p_answer;
		@(posedge clk_in) disable iff (srst_in)
		s_taken |=> !avs_waitrequest_out;
	endproperty
	a_answer: assert property (p_answer) else $error("no answer");
	property p_irq;
		@(posedge clk_in) disable iff (srst_in)
		(ce_in && !srst_in) |=> irq_out ==
		|(timer_flag_register_ff & $past(timer_mask_register_ff));
	endproperty
	a_irq: assert property (p_irq) else $error("irq mask");
	property p_bottom;
		@(posedge clk_in) disable iff (srst_in)
		(ce_in && !srst_in) |=>
		ends_out.at_bottom == (timer_count_value_ff == t16b_pkg::BOTTOM_VAL);
	endproperty
	a_bottom: assert property (p_bottom) else $error("bottom flag");
endmodule // t16b_core

// ---- t16b_cpu_model.sv ----
// processor side model: byte-wide avalon-mm master with 16-bit access pairs
`timescale 1ns/100ps
module t16b_cpu_model (
	input  wire logic        clk_in,
	input  wire logic        waitrequest_in,
	output logic      [3:0]  address_out,
	output logic             read_out,
	output logic             write_out,
	output logic      [31:0] writedata_out,
	output logic      [3:0]  byteenable_out
);
	// high while a byte pair is in flight, so no handler can reuse holding
	logic int_off;

	// idle bus at time zero; only the low byte lane is ever used
	initial begin
		address_out = 4'h0;
		read_out = 1'b0;
		write_out = 1'b0;
		writedata_out = 32'h00000000;
		byteenable_out = 4'h1;
		int_off = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// one transfer; request held until the edge that sees waitrequest low
	task automatic xfer(input logic [3:0] idx, input logic wr,
		input logic [7:0] d);
		@(posedge clk_in);
		address_out <= idx;
		read_out <= ~wr;
		write_out <= wr;
		writedata_out <= {24'h000000, d};
		// no cycle limit here: only the bench watchdog ends a hang
		do begin
			@(posedge clk_in);
		end while (waitrequest_in !== 1'b0);
		read_out <= 1'b0;
		write_out <= 1'b0;
	endtask

	// high byte goes first so the low write commits the whole word
	task automatic write16(input logic [3:0] lo, input logic [15:0] d);
		int_off = 1'b1;
		xfer(lo + 4'h1, 1'b1, d[15:8]);
		xfer(lo, 1'b1, d[7:0]);
		int_off = 1'b0;
	endtask

	// low byte first so the high byte is frozen in holding
	task automatic read16(input logic [3:0] lo);
		int_off = 1'b1;
		xfer(lo, 1'b0, 8'h00);
		xfer(lo + 4'h1, 1'b0, 8'h00);
		int_off = 1'b0;
	endtask
endmodule // t16b_cpu_model

// ---- t16b_core_tb.sv ----
// self-checking testbench of the 16-bit timer byte access core
`timescale 1ns/100ps
module t16b_core_tb;
	logic                 clk_in;
	logic                 srst_in;
	logic                 ce_in;
	logic [3:0]           addr;
	logic                 rd;
	logic                 wr;
	logic [31:0]          wdata;
	logic [31:0]          rdata;
	logic [3:0]           be;
	logic                 wreq;
	t16b_pkg::t16b_pins_t pins;
	logic [1:0]           pwm;
	logic                 irq;
	t16b_pkg::t16b_ends_t ends;
	logic [7:0]           exp_q[$];
	int                   n_mismatch;
	int                   tests_run;
	int                   k;
	logic [15:0]          v;
	logic [15:0]          tops[4] = '{16'hffff, 16'h00ff, 16'h01ff, 16'h03ff};
	logic [7:0]           cs_tab[3] = '{8'h00, 8'h06, 8'h07};

	t16b_core u_t16b_core (.clk_in(clk_in), .srst_in(srst_in), .ce_in(ce_in),
		.avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
		.avs_writedata_in(wdata), .avs_byteenable_in(be),
		.avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
		.pins_in(pins), .compare_output_pins_out(pwm), .irq_out(irq),
		.ends_out(ends));
	t16b_cpu_model u_t16b_cpu_model (.clk_in(clk_in),
		.waitrequest_in(wreq), .address_out(addr), .read_out(rd),
		.write_out(wr), .writedata_out(wdata), .byteenable_out(be));

	////////////////////////////////////////////////////////////////////////
	// shared helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr8(input logic [3:0] a, input logic [7:0] d);
		u_t16b_cpu_model.xfer(a, 1'b1, d);
	endtask
	task automatic rd8(input logic [3:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		u_t16b_cpu_model.xfer(a, 1'b0, 8'h00);
	endtask
	task automatic wr16(input logic [3:0] a, input logic [15:0] d);
		u_t16b_cpu_model.write16(a, d);
	endtask
	task automatic rd16(input logic [3:0] a, input logic [15:0] e);
		exp_q.push_back(e[7:0]);
		exp_q.push_back(e[15:8]);
		u_t16b_cpu_model.read16(a);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	task automatic tally_and_finish();
		if (exp_q.size() != 0)
			n_mismatch++;
		$display("mismatches %0d, checks %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// result watcher: each answered read retires the oldest note
	always @(posedge clk_in) begin
		if (rd === 1'b1 && wreq === 1'b0) begin
			if (exp_q.size() == 0) begin
				n_mismatch++;
				$display("[FAIL] t=%0t got=%h exp=%h", $time, rdata, 0);
			end else begin
				chk(rdata, {24'h000000, exp_q.pop_front()});
			end
		end
	end

	// free-running 100 MHz clock
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	// hang guard, far beyond the several hundred cycles the run needs
	initial begin
		repeat (20000) @(posedge clk_in);
		n_mismatch++;
		tally_and_finish();
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(19943));
		n_mismatch = 0;
		tests_run = 0;
		srst_in = 1'b1;
		ce_in = 1'b1;
		pins = '0;
		idle(3);
		srst_in <= 1'b0;
		idle(2);
		// every place reads zero after reset, unmapped ones stay zero
		for (int i = 0; i < 16; i++)
			rd8(i[3:0], 8'h00);
		chk({29'h0, ends}, 32'h00000004);
		wr8(4'hc, 8'hff);
		rd8(4'hc, 8'h00);
		// control bytes are plain storage; capture sources kept quiet
		v = 16'($urandom);
		wr8(t16b_pkg::ADDR_CTRL_A, v[7:0]);
		rd8(t16b_pkg::ADDR_CTRL_A, v[7:0]);
		wr8(t16b_pkg::ADDR_CTRL_B, v[15:8] & 8'hc0);
		rd8(t16b_pkg::ADDR_CTRL_B, v[15:8] & 8'hc0);
		wr8(t16b_pkg::ADDR_CTRL_A, 8'h00);
		wr8(t16b_pkg::ADDR_CTRL_B, 8'h00);
		// one holding byte serves every wide register
		v = 16'($urandom);
		wr16(t16b_pkg::ADDR_CNT_LO, v);
		rd16(t16b_pkg::ADDR_CNT_LO, v);
		wr8(t16b_pkg::ADDR_CMPA_HI, 8'h3c);
		wr8(t16b_pkg::ADDR_CNT_LO, 8'h96);
		rd16(t16b_pkg::ADDR_CNT_LO, 16'h3c96);
		wr8(t16b_pkg::ADDR_CMPB_LO, 8'h11);
		rd8(t16b_pkg::ADDR_CMPA_HI, 8'h00);
		rd8(t16b_pkg::ADDR_CNT_HI, 8'h3c);
		rd16(t16b_pkg::ADDR_CMPB_LO, 16'h3c11);
		// capture only writable while it defines top
		wr16(t16b_pkg::ADDR_CAP_LO, 16'h5a5a);
		rd16(t16b_pkg::ADDR_CAP_LO, 16'h0000);
		wr8(t16b_pkg::ADDR_CTRL_B, 8'h28);
		wr16(t16b_pkg::ADDR_CAP_LO, 16'h5a5a);
		rd16(t16b_pkg::ADDR_CAP_LO, 16'h5a5a);
		// end points for each fixed top, then compare a as top
		for (int t = 0; t < 5; t++) begin
			v = (t < 4) ? tops[t] : (16'($urandom) | 16'h0400);
			if (t == 4)
				wr16(t16b_pkg::ADDR_CMPA_LO, v);
			wr8(t16b_pkg::ADDR_CTRL_B, 8'(t << 3));
			wr16(t16b_pkg::ADDR_CNT_LO, v);
			idle(3);
			chk({29'h0, ends}, {29'h0, 1'b0, v == 16'hffff, 1'b1});
		end
		wr16(t16b_pkg::ADDR_CNT_LO, 16'h0000);
		idle(3);
		chk({29'h0, ends}, 32'h00000004);
		// compare match flags while counting from zero at full rate
		wr8(t16b_pkg::ADDR_CTRL_B, 8'h00);
		wr16(t16b_pkg::ADDR_CMPA_LO, 16'h0005);
		wr16(t16b_pkg::ADDR_CMPB_LO, 16'h0007);
		wr8(t16b_pkg::ADDR_CTRL_B, 8'h01);
		idle(20);
		wr16(t16b_pkg::ADDR_CMPA_LO, 16'h0003);
		wr8(t16b_pkg::ADDR_CTRL_B, 8'h00);
		rd8(t16b_pkg::ADDR_FLAGS, 8'h06);
		rd16(t16b_pkg::ADDR_CMPA_LO, 16'h0003);
		chk({31'h0, irq}, 32'h00000000);
		wr8(t16b_pkg::ADDR_MASK, 8'h04);
		idle(3);
		chk({31'h0, irq}, 32'h00000001);
		wr8(t16b_pkg::ADDR_MASK, 8'h01);
		idle(3);
		chk({31'h0, irq}, 32'h00000000);
		wr8(t16b_pkg::ADDR_FLAGS, 8'h06);
		rd8(t16b_pkg::ADDR_FLAGS, 8'h00);
		// both outputs set at top; a goes quiet once it defines top
		wr8(t16b_pkg::ADDR_CTRL_A, 8'h06);
		wr16(t16b_pkg::ADDR_CNT_LO, 16'hffff);
		idle(3);
		chk({30'h0, pwm}, 32'h00000003);
		wr8(t16b_pkg::ADDR_CTRL_B, 8'h20);
		idle(3);
		chk({30'h0, pwm}, 32'h00000002);
		wr8(t16b_pkg::ADDR_CTRL_B, 8'h00);
		wr8(t16b_pkg::ADDR_CTRL_A, 8'h00);
		// external edges counted, none with the source off
		foreach (cs_tab[j]) begin
			k = 1 + $urandom % 8;
			wr16(t16b_pkg::ADDR_CNT_LO, 16'h0000);
			wr8(t16b_pkg::ADDR_CTRL_B, cs_tab[j]);
			repeat (k) begin
				pins.count_pin <= 1'b1;
				idle(4);
				pins.count_pin <= 1'b0;
				idle(4);
			end
			idle(6);
			wr8(t16b_pkg::ADDR_CTRL_B, 8'h00);
			rd16(t16b_pkg::ADDR_CNT_LO, (cs_tab[j] != 8'h00) ? 16'(k) : 16'h0000);
		end
		// random edge counts may have passed both compare values
		wr8(t16b_pkg::ADDR_FLAGS, 8'h0f);
		// capture from pin then comparator, filter off then on
		for (int s = 0; s < 2; s++) begin
			v = 16'($urandom);
			wr8(t16b_pkg::ADDR_CTRL_A, 8'(s));
			wr16(t16b_pkg::ADDR_CNT_LO, v);
			wr8(t16b_pkg::ADDR_CTRL_B, {s[0], 7'h40});
			if (s == 0)
				pins.capture_pin <= 1'b1;
			else
				pins.comparator <= 1'b1;
			idle(16);
			rd8(t16b_pkg::ADDR_FLAGS, 8'h08);
			rd16(t16b_pkg::ADDR_CAP_LO, v);
			wr8(t16b_pkg::ADDR_FLAGS, 8'h08);
			pins <= '0;
			idle(16);
			rd8(t16b_pkg::ADDR_FLAGS, 8'h00);
		end
		// a pulse that comes and goes while frozen leaves no capture
		ce_in <= 1'b0;
		pins.comparator <= 1'b1;
		idle(10);
		pins.comparator <= 1'b0;
		idle(2);
		ce_in <= 1'b1;
		idle(10);
		rd8(t16b_pkg::ADDR_FLAGS, 8'h00);
		idle(4);
		tally_and_finish();
	end
endmodule // t16b_core_tb
